// *** pkg/clk_ctrl_pkg.sv ***
// clk_ctrl_pkg: shared constants and carrier types for the clock switch controller
// assumes: one 125 MHz clock; register port offsets are word indices
package clk_ctrl_pkg;

  // register map
  localparam logic [3:0] OFF_OSC_CTRL   = 4'h0;
  localparam logic [3:0] OFF_UNLOCK     = 4'h1;
  localparam logic [3:0] OFF_CONFIG     = 4'h2;
  localparam logic [3:0] OFF_SRC_STATUS = 4'h3;
  localparam logic [7:0] UNLOCK_HI_KEY  = 8'hA5;
  localparam logic [7:0] UNLOCK_LO_KEY  = 8'h5A;

  // oscillator control register field positions
  localparam int CUR_POS    = 12;
  localparam int NEXT_POS   = 8;
  localparam int FREEZE_POS = 7;
  localparam int PLLOK_POS  = 5;
  localparam int FAIL_POS   = 3;
  localparam int KEEP_POS   = 1;
  localparam int REQ_POS    = 0;

  // source codes of the three-bit select fields
  localparam logic [2:0] SRC_FRC      = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
  localparam logic [2:0] SRC_PRI      = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
  localparam logic [2:0] SRC_LPXTAL   = 3'h4;
  localparam logic [2:0] SRC_SLOW_INTERNAL_RC     = 3'h5;
  localparam logic [2:0] SRC_FRC_DIVN = 3'h7;

  // timing: settle count of new-source cycles, idle wake delay
  localparam logic [3:0] SETTLE_CYCLES = 4'hA;
  localparam logic [1:0] IDLE_WAKE_CYC = 2'h2;
  localparam logic       CFG_RESET     = 1'b1;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // enables for oscillators and clocks
  typedef struct packed {
    logic frc_on;
    logic pri_on;
    logic lpxtal_on;
    logic slow_internal_rc_on;
    logic pll_on;
    logic sysclk_on;
    logic cpu_clk_on;
  } osc_en_t;

  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_IDLE, PM_WAKE} pm_state_t;
  typedef enum logic [2:0] {SW_IDLE, SW_START, SW_QUAL, SW_SETTLE, SW_DONE} sw_state_t;

endpackage

// *** verilog/settle_counter.sv ***
// settle_counter: counts rising edges of the qualified new source
// assumes: src_tick is a one-cycle pulse per new-source cycle, already synchronous
`timescale 1ns/1ps
`default_nettype none
module settle_counter #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  // control
  input  wire logic         start,
  input  wire logic         src_tick,
  input  wire logic [W-1:0] target,
  // status
  output var  logic         done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         done;
  } st_t;

  st_t s_q;
  st_t s_d;

  // restart clears the count; done stays high until the next start
  always_comb
  begin
    s_d = s_q;
    if (start)
    begin
      s_d.cnt  = '0;
      s_d.run  = 1'b1;
      s_d.done = 1'b0;
    end
    else if (s_q.run && src_tick)
    begin
      s_d.cnt = s_q.cnt + W'(1);
      if (s_q.cnt + W'(1) == target)
      begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done = s_q.done;

endmodule
`default_nettype wire

// *** verilog/power_save_decode.sv ***
// power_save_decode: turns the power-save instruction into sleep or idle requests
// assumes: instr_valid is a one-cycle strobe from the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module power_save_decode (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // instruction
  input  wire logic instr_valid,
  input  wire logic instr_operand,
  // mode requests
  output var  logic sleep_req,
  output var  logic idle_req
);

  typedef struct packed {
    logic sleep;
    logic idle;
  } st_t;

  st_t s_q;
  st_t s_d;

  // operand 0 asks for sleep, 1 for idle; one-cycle pulses
  always_comb
  begin
    s_d.sleep = instr_valid && !instr_operand;
    s_d.idle  = instr_valid && instr_operand;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sleep_req = s_q.sleep;
  assign idle_req  = s_q.idle;

endmodule
`default_nettype wire

// *** verilog/clock_switch_power_modes.sv ***
// clock_switch_power_modes: clock switch sequencer, fail-safe fallback, sleep and idle
// assumes: oscillator ready, pll lock, crystal timer, failure and wake inputs are
// synchronous to ref_clk; new_src_tick pulses once per cycle of the selected new source
`timescale 1ns/1ps
`default_nettype none

module clock_switch_power_modes (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  // register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output var  logic [15:0]           reg_rdata,
  // configuration straps
  input  wire logic                  switch_monitor_cfg_bit,
  input  wire logic [2:0]            initial_source_cfg,
  input  wire logic                  watchdog_enabled,
  // oscillator feedback
  input  wire logic                  crystal_timer_done,
  input  wire logic                  pll_locked,
  input  wire logic                  new_src_tick,
  input  wire logic                  osc_fail,
  // power-save instruction and wake events
  input  wire logic                  instr_valid,
  input  wire logic                  instr_operand,
  input  wire logic                  irq_pending,
  input  wire logic                  watchdog_timeout,
  // outputs
  output var  clk_ctrl_pkg::osc_en_t osc_en,
  output var  logic [2:0]            sys_src_sel,
  output var  logic                  clock_fail_trap,
  output var  logic                  watchdog_clear,
  output var  logic                  cpu_resume
);

  typedef struct packed {
    logic                    cfg_lat;
    logic                    cfg_taken;
    logic [2:0]              cur;
    logic [2:0]              nxt;
    logic                    req;
    logic                    freeze;
    logic                    pll_ok;
    logic                    fail;
    logic                    keep;
    logic                    unl_hi;
    logic                    unl_lo;
    clk_ctrl_pkg::sw_state_t sw;
    clk_ctrl_pkg::pm_state_t pm;
    logic                    from_idle;
    logic [1:0]              wake_cnt;
    logic                    irq_hold;
    logic [15:0]             rdata;
    clk_ctrl_pkg::osc_en_t   en;
    logic                    trap;
    logic                    wdt_clr;
    logic                    resume;
  } st_t;

  st_t  s_q;
  st_t  s_d;
  logic sleep_req;
  logic idle_req;
  logic settle_start;
  logic settle_done;
  logic sw_on;
  logic mon_on;
  logic uses_pll;
  logic xtal_src;
  logic [15:0] osc_word;

  power_save_decode u_dec (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .instr_valid   (instr_valid),
    .instr_operand (instr_operand),
    .sleep_req     (sleep_req),
    .idle_req      (idle_req)
  );

  settle_counter #(.W(4)) u_settle (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .start    (settle_start),
    .src_tick (new_src_tick),
    .target   (clk_ctrl_pkg::SETTLE_CYCLES),
    .done     (settle_done)
  );

  // switching and monitor follow the latched configuration bit
  assign sw_on    = s_q.cfg_taken && !s_q.cfg_lat;
  assign mon_on   = sw_on;
  assign uses_pll = (s_q.nxt == clk_ctrl_pkg::SRC_FRC_PLL) ||
                    (s_q.nxt == clk_ctrl_pkg::SRC_PRI_PLL);
  assign xtal_src = (s_q.nxt == clk_ctrl_pkg::SRC_PRI) ||
                    (s_q.nxt == clk_ctrl_pkg::SRC_PRI_PLL) ||
                    (s_q.nxt == clk_ctrl_pkg::SRC_LPXTAL);
  assign settle_start = (s_q.sw == clk_ctrl_pkg::SW_QUAL) &&
                        (!xtal_src || crystal_timer_done) &&
                        (!uses_pll || pll_locked);

  // read image of the oscillator control register; request gated when off
  assign osc_word = {1'b0, s_q.cur, 1'b0, s_q.nxt, s_q.freeze, 1'b0, s_q.pll_ok,
                     1'b0, s_q.fail, 1'b0, s_q.keep, s_q.req && sw_on};

  // one process for configuration, registers, switch sequencer and power modes
  always_comb
  begin
    s_d         = s_q;
    s_d.trap    = 1'b0;
    s_d.wdt_clr = 1'b0;
    s_d.resume  = 1'b0;
    s_d.rdata   = '0;
    // catch straps once after reset release
    if (!s_q.cfg_taken)
    begin
      s_d.cfg_lat   = switch_monitor_cfg_bit;
      s_d.cfg_taken = 1'b1;
      s_d.cur       = initial_source_cfg;
      s_d.nxt       = initial_source_cfg;
    end
    // register reads, data returned next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        clk_ctrl_pkg::OFF_OSC_CTRL:   s_d.rdata = osc_word;
        clk_ctrl_pkg::OFF_CONFIG:     s_d.rdata = {13'h0000, watchdog_enabled,
                                                   mon_on, sw_on};
        clk_ctrl_pkg::OFF_SRC_STATUS: s_d.rdata = {13'h0000, sys_src_sel};
        default:                      s_d.rdata = 16'h0000;
      endcase
    end
    // unlock keys arm a one-shot permission per byte
    if (reg_wr && reg_addr == clk_ctrl_pkg::OFF_UNLOCK)
    begin
      if (reg_wdata[15:8] == clk_ctrl_pkg::UNLOCK_HI_KEY)
        s_d.unl_hi = 1'b1;
      if (reg_wdata[7:0] == clk_ctrl_pkg::UNLOCK_LO_KEY)
        s_d.unl_lo = 1'b1;
    end
    if (reg_wr && reg_addr == clk_ctrl_pkg::OFF_OSC_CTRL)
    begin
      // high byte write consumes its unlock; next select kept while switching
      if (s_q.unl_hi)
      begin
        s_d.unl_hi = 1'b0;
        if (s_q.sw == clk_ctrl_pkg::SW_IDLE)
          s_d.nxt = reg_wdata[clk_ctrl_pkg::NEXT_POS +: 3];
      end
      // low byte write: fail clear, keep-alive, request; freeze needs switching without monitor, never true
      if (s_q.unl_lo)
      begin
        s_d.unl_lo = 1'b0;
        s_d.keep   = reg_wdata[clk_ctrl_pkg::KEEP_POS];
        if (sw_on && !mon_on)
          s_d.freeze = s_q.freeze | reg_wdata[clk_ctrl_pkg::FREEZE_POS];
        if (!reg_wdata[clk_ctrl_pkg::FAIL_POS])
          s_d.fail = 1'b0;
        if (sw_on && !s_q.freeze && reg_wdata[clk_ctrl_pkg::REQ_POS])
          s_d.req = 1'b1;
      end
    end
    // pll status follows lock while no switch is pending
    if (s_q.sw == clk_ctrl_pkg::SW_IDLE)
      s_d.pll_ok = pll_locked;
    // switch sequencer, cpu not stalled throughout
    case (s_q.sw)
      clk_ctrl_pkg::SW_IDLE:
        if (s_q.req && sw_on && s_q.pm == clk_ctrl_pkg::PM_RUN)
          s_d.sw = clk_ctrl_pkg::SW_START;
      clk_ctrl_pkg::SW_START:
        if (s_q.nxt == s_q.cur)
        begin
          s_d.req = 1'b0; // redundant switch aborted
          s_d.sw  = clk_ctrl_pkg::SW_IDLE;
        end
        else
        begin
          s_d.pll_ok = 1'b0;
          s_d.fail   = 1'b0;
          s_d.sw     = clk_ctrl_pkg::SW_QUAL;
        end
      clk_ctrl_pkg::SW_QUAL:
        if (settle_start)
          s_d.sw = clk_ctrl_pkg::SW_SETTLE;
      clk_ctrl_pkg::SW_SETTLE:
        if (settle_done)
          s_d.sw = clk_ctrl_pkg::SW_DONE;
      clk_ctrl_pkg::SW_DONE:
      begin
        s_d.cur    = s_q.nxt;
        s_d.req    = 1'b0;
        s_d.pll_ok = pll_locked;
        s_d.sw     = clk_ctrl_pkg::SW_IDLE;
      end
      default:
        s_d.sw = clk_ctrl_pkg::SW_IDLE;
    endcase
    // monitor failure: trap and fall back, keeping pll scaling
    if (mon_on && osc_fail && s_q.pm != clk_ctrl_pkg::PM_SLEEP)
    begin
      s_d.trap = 1'b1;
      s_d.fail = 1'b1;
      s_d.req  = 1'b0;
      s_d.sw   = clk_ctrl_pkg::SW_IDLE;
      s_d.cur  = (s_q.cur == clk_ctrl_pkg::SRC_PRI_PLL ||
                  s_q.cur == clk_ctrl_pkg::SRC_FRC_PLL) ?
                 clk_ctrl_pkg::SRC_FRC_PLL : clk_ctrl_pkg::SRC_FRC;
      s_d.nxt  = s_d.cur;
    end
    // power modes; cur is untouched so sleep wakes on the same source
    case (s_q.pm)
      clk_ctrl_pkg::PM_RUN:
        if (sleep_req || idle_req)
        begin
          s_d.wdt_clr   = 1'b1;
          s_d.from_idle = idle_req;
          s_d.irq_hold  = irq_pending;
          s_d.pm        = sleep_req ? clk_ctrl_pkg::PM_SLEEP : clk_ctrl_pkg::PM_IDLE;
        end
      clk_ctrl_pkg::PM_SLEEP, clk_ctrl_pkg::PM_IDLE:
      begin
        s_d.irq_hold = 1'b0;
        if (s_q.irq_hold || irq_pending || watchdog_timeout)
        begin
          s_d.pm       = clk_ctrl_pkg::PM_WAKE;
          s_d.wake_cnt = '0;
        end
      end
      clk_ctrl_pkg::PM_WAKE:
      begin
        s_d.wake_cnt = s_q.wake_cnt + 2'h1;
        if (s_q.wake_cnt + 2'h1 == clk_ctrl_pkg::IDLE_WAKE_CYC)
        begin
          s_d.resume = 1'b1;
          s_d.pm     = clk_ctrl_pkg::PM_RUN;
        end
      end
      default:
        s_d.pm = clk_ctrl_pkg::PM_RUN;
    endcase
    // oscillator enables: current and incoming source (incoming SRC_FRC_DIVN and SRC_SLOW_INTERNAL_RC not counted), old one dropped
    s_d.en.frc_on    = (s_q.cur == clk_ctrl_pkg::SRC_FRC) ||
                       (s_q.cur == clk_ctrl_pkg::SRC_FRC_PLL) ||
                       (s_q.cur == clk_ctrl_pkg::SRC_FRC_DIVN) ||
                       (s_q.sw != clk_ctrl_pkg::SW_IDLE &&
                        (s_q.nxt == clk_ctrl_pkg::SRC_FRC ||
                         s_q.nxt == clk_ctrl_pkg::SRC_FRC_PLL));
    s_d.en.pri_on    = (s_q.cur == clk_ctrl_pkg::SRC_PRI) ||
                       (s_q.cur == clk_ctrl_pkg::SRC_PRI_PLL) ||
                       (s_q.sw != clk_ctrl_pkg::SW_IDLE && xtal_src &&
                        s_q.nxt != clk_ctrl_pkg::SRC_LPXTAL);
    s_d.en.lpxtal_on = (s_q.cur == clk_ctrl_pkg::SRC_LPXTAL) || s_q.keep ||
                       (s_q.sw != clk_ctrl_pkg::SW_IDLE &&
                        s_q.nxt == clk_ctrl_pkg::SRC_LPXTAL);
    s_d.en.pll_on    = (s_q.cur == clk_ctrl_pkg::SRC_FRC_PLL) ||
                       (s_q.cur == clk_ctrl_pkg::SRC_PRI_PLL) ||
                       (s_q.sw != clk_ctrl_pkg::SW_IDLE && uses_pll);
    // slow rc: watchdog keeps it always, monitor except in sleep
    s_d.en.slow_internal_rc_on   = (s_q.cur == clk_ctrl_pkg::SRC_SLOW_INTERNAL_RC) || watchdog_enabled ||
                       (mon_on && s_d.pm != clk_ctrl_pkg::PM_SLEEP);
    // sleep drops the system clock and on-chip oscillators except slow rc while the watchdog is enabled and lpxtal while keep is set
    if (s_d.pm == clk_ctrl_pkg::PM_SLEEP)
    begin
      s_d.en.frc_on    = 1'b0;
      s_d.en.pri_on    = 1'b0;
      s_d.en.pll_on    = 1'b0;
      s_d.en.lpxtal_on = s_q.keep;
      s_d.en.slow_internal_rc_on   = watchdog_enabled;
    end
    s_d.en.sysclk_on  = s_d.pm != clk_ctrl_pkg::PM_SLEEP;
    s_d.en.cpu_clk_on = s_d.pm == clk_ctrl_pkg::PM_RUN;
  end

  // single state register; straps are caught after release, not at reset
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q         <= '0;
      s_q.cfg_lat <= clk_ctrl_pkg::CFG_RESET;
      s_q.sw      <= clk_ctrl_pkg::SW_IDLE;
      s_q.pm      <= clk_ctrl_pkg::PM_RUN;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata       = s_q.rdata;
  assign osc_en          = s_q.en;
  assign sys_src_sel     = s_q.cur;
  assign clock_fail_trap = s_q.trap;
  assign watchdog_clear  = s_q.wdt_clr;
  assign cpu_resume      = s_q.resume;

  sequence idle_wake_s;
    s_q.pm == clk_ctrl_pkg::PM_IDLE ##1 s_q.pm == clk_ctrl_pkg::PM_WAKE;
  endsequence

  chk_disabled_no_req: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !sw_on |-> osc_word[0] == 1'b0 && !s_q.req) else $error("request bit set while off");
  chk_redundant_abort: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_q.sw == clk_ctrl_pkg::SW_START && s_q.nxt == s_q.cur && !osc_fail)
    |=> !s_q.req) else $error("redundant switch not aborted");
  chk_start_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_q.sw == clk_ctrl_pkg::SW_START && s_q.nxt != s_q.cur)
    |=> !s_q.pll_ok) else $error("pll ok not cleared on start");
  chk_settle_order: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_q.sw == clk_ctrl_pkg::SW_SETTLE && !settle_done && !osc_fail)
    |=> s_q.cur == $past(s_q.cur)) else $error("changeover before settle");
  chk_done_copy: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_q.sw == clk_ctrl_pkg::SW_DONE && !osc_fail)
    |=> s_q.cur == $past(s_q.nxt) && !s_q.req) else $error("copy failed");
  chk_fail_trap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (mon_on && osc_fail && s_q.pm != clk_ctrl_pkg::PM_SLEEP)
    |=> clock_fail_trap && s_q.fail) else $error("failure not trapped");
  chk_sleep_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_q.pm == clk_ctrl_pkg::PM_SLEEP |-> !osc_en.sysclk_on && !osc_en.frc_on)
    else $error("clock running in sleep");
  chk_sleep_wdt_clr: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_q.pm == clk_ctrl_pkg::PM_RUN && sleep_req) |=> watchdog_clear)
    else $error("watchdog not cleared on entry");
  chk_idle_resume: assert property (@(posedge ref_clk) disable iff (!arst_n)
    idle_wake_s |-> ##[1:3] cpu_resume) else $error("idle wake too slow");
  chk_freeze_block: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (s_q.freeze && !s_q.req) |=> !s_q.req) else $error("switch after freeze");

endmodule
`default_nettype wire

// *** verification/clock_switch_power_modes_tb.sv ***
// clock_switch_power_modes_tb: self-checking bench for the clock switch controller
// assumes: clk_ctrl_pkg compiled first; bench drives every port, no far-side model
`timescale 1ns/1ps
`default_nettype none
module clock_switch_power_modes_tb;
  logic                  ref_clk = 1'b0;
  logic                  arst_n, cfg_bit, wdt_en, xtal_done, pll_lock, tick, fail;
  logic [3:0]            reg_addr;
  logic [15:0]           reg_wdata, reg_rdata, rv;
  logic                  reg_wr, reg_rd, instr_valid, instr_operand, irq, wdt_to;
  logic [2:0]            init_src, sys_src_sel, want_src;
  logic                  trap, wdt_clr, resume;
  clk_ctrl_pkg::osc_en_t osc_en;
  int                    err_total = 0;
  int                    checks_done = 0;
  int                    n;

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  clock_switch_power_modes i_clock_switch_power_modes (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .switch_monitor_cfg_bit(cfg_bit), .initial_source_cfg(init_src),
    .watchdog_enabled(wdt_en), .crystal_timer_done(xtal_done), .pll_locked(pll_lock),
    .new_src_tick(tick), .osc_fail(fail), .instr_valid(instr_valid),
    .instr_operand(instr_operand), .irq_pending(irq), .watchdog_timeout(wdt_to),
    .osc_en(osc_en), .sys_src_sel(sys_src_sel), .clock_fail_trap(trap),
    .watchdog_clear(wdt_clr), .cpu_resume(resume)
  );

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // selector keeps one bounded wait loop for every awaited output
  function automatic logic pick(input int k);
    case (k)
      0:       return trap;
      1:       return wdt_clr;
      2:       return resume;
      3:       return osc_en.sysclk_on;
      default: return sys_src_sel === want_src;
    endcase
  endfunction

  task automatic wait_hi(input int k, output int cnt);
    cnt = 0;
    // look just after the calling edge so a one-cycle pulse launched there is seen
    #1;
    while (pick(k) !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (cnt > 60)
      begin
        err_total++;
        $display("CHECK FAILED wait %0d expected 1 seen 0", k);
        final_report();
      end
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data is only valid in the cycle right after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // unlock then write one byte of the oscillator control register
  task automatic osc_hi(input logic [2:0] nxt);
    reg_write(clk_ctrl_pkg::OFF_UNLOCK, {clk_ctrl_pkg::UNLOCK_HI_KEY, 8'h00});
    reg_write(clk_ctrl_pkg::OFF_OSC_CTRL, {5'h00, nxt, 8'h00});
  endtask

  task automatic osc_lo(input logic [7:0] lo);
    reg_write(clk_ctrl_pkg::OFF_UNLOCK, {8'h00, clk_ctrl_pkg::UNLOCK_LO_KEY});
    reg_write(clk_ctrl_pkg::OFF_OSC_CTRL, {8'h00, lo});
  endtask

  task automatic ticks(input int k);
    repeat (k)
    begin
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
    end
  endtask

  // straps are sampled on the first edge after release
  task automatic do_reset(input logic cfg, input logic [2:0] src);
    arst_n   <= 1'b0;
    cfg_bit  <= cfg;
    init_src <= src;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic s_disabled();
    do_reset(1'b1, clk_ctrl_pkg::SRC_PRI);
    osc_hi(clk_ctrl_pkg::SRC_SLOW_INTERNAL_RC);
    osc_lo(8'h01);
    ticks(12);
    reg_read(clk_ctrl_pkg::OFF_OSC_CTRL, rv);
    chk("req bit", 16'h0000, {15'h0, rv[0]});
    chk("cur field", {13'h0, clk_ctrl_pkg::SRC_PRI}, {13'h0, rv[14:12]});
    chk("sys src", {13'h0, clk_ctrl_pkg::SRC_PRI}, {13'h0, sys_src_sel});
    reg_read(clk_ctrl_pkg::OFF_CONFIG, rv);
    chk("config off", 16'h0004, rv);
  endtask

  task automatic s_redundant();
    do_reset(1'b0, clk_ctrl_pkg::SRC_FRC);
    reg_read(clk_ctrl_pkg::OFF_CONFIG, rv);
    chk("config on", 16'h0007, rv);
    reg_write(clk_ctrl_pkg::OFF_OSC_CTRL, {5'h00, clk_ctrl_pkg::SRC_SLOW_INTERNAL_RC, 8'h00});
    reg_read(clk_ctrl_pkg::OFF_OSC_CTRL, rv);
    chk("next field", {13'h0, clk_ctrl_pkg::SRC_FRC}, {13'h0, rv[10:8]});
    osc_hi(clk_ctrl_pkg::SRC_FRC);
    osc_lo(8'h01);
    repeat (4) @(posedge ref_clk);
    reg_read(clk_ctrl_pkg::OFF_OSC_CTRL, rv);
    chk("req bit", 16'h0000, {15'h0, rv[0]});
  endtask

  // crystal with pll: held until the crystal timer (lock already high), then ten new-source cycles
  // starts from plain fast rc, never pll mode to pll mode
  task automatic s_switch();
    pll_lock <= 1'b1; // pll-ok reads one before the start so its clearing is visible
    osc_hi(clk_ctrl_pkg::SRC_PRI_PLL);
    osc_lo(8'h01);
    ticks(12);
    reg_read(clk_ctrl_pkg::OFF_OSC_CTRL, rv);
    chk("req bit", 16'h0001, {15'h0, rv[0]});
    chk("lock and fail", 16'h0000, {14'h0, rv[5], rv[3]});
    chk("cpu clk", 16'h0001, {15'h0, osc_en.cpu_clk_on});
    xtal_done <= 1'b1;
    pll_lock  <= 1'b1;
    ticks(9);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("sys src", {13'h0, clk_ctrl_pkg::SRC_FRC}, {13'h0, sys_src_sel});
    want_src = clk_ctrl_pkg::SRC_PRI_PLL;
    ticks(1);
    wait_hi(4, n);
    reg_read(clk_ctrl_pkg::OFF_OSC_CTRL, rv);
    chk("req and cur", {12'h0, clk_ctrl_pkg::SRC_PRI_PLL, 1'b0}, {12'h0, rv[14:12], rv[0]});
    chk("old src off", 16'h0000, {15'h0, osc_en.frc_on});
  endtask

  task automatic s_fail();
    @(posedge ref_clk);
    fail <= 1'b1;
    @(posedge ref_clk);
    fail <= 1'b0;
    wait_hi(0, n);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("fallback", {13'h0, clk_ctrl_pkg::SRC_FRC_PLL}, {13'h0, sys_src_sel});
    reg_read(clk_ctrl_pkg::OFF_OSC_CTRL, rv);
    chk("fail flag", 16'h0001, {15'h0, rv[3]});
    reg_read(clk_ctrl_pkg::OFF_SRC_STATUS, rv);
    chk("src status", {13'h0, clk_ctrl_pkg::SRC_FRC_PLL}, rv);
  endtask

  task automatic s_sleep();
    @(posedge ref_clk);
    instr_valid   <= 1'b1;
    instr_operand <= 1'b0;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    wait_hi(1, n);
    chk("sleep en", 16'h0001, {13'h0, osc_en.sysclk_on, osc_en.frc_on, osc_en.slow_internal_rc_on});
    @(posedge ref_clk);
    irq <= 1'b1;
    wait_hi(3, n);
    chk("wake src", {13'h0, clk_ctrl_pkg::SRC_FRC_PLL}, {13'h0, sys_src_sel});
    irq <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // coincident interrupt must still let entry finish, then wake
  task automatic s_idle(input logic coinc);
    @(posedge ref_clk);
    instr_valid   <= 1'b1;
    instr_operand <= 1'b1;
    irq           <= coinc;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    wait_hi(1, n);
    if (!coinc)
    begin
      chk("idle en", 16'h0003, {13'h0, osc_en.cpu_clk_on, osc_en.sysclk_on, osc_en.slow_internal_rc_on});
      @(posedge ref_clk);
      wdt_to <= 1'b1;
    end
    else
      irq <= 1'b0; // only the interrupt held at entry can wake now
    wait_hi(2, n);
    if (!coinc)
      chk("wake delay", 16'h0001, {15'h0, n >= 2 && n <= 4});
    irq    <= 1'b0;
    wdt_to <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("cpu clk", 16'h0001, {15'h0, osc_en.cpu_clk_on});
  endtask

  initial
  begin
    arst_n        = 1'b0;
    cfg_bit       = 1'b1;
    init_src      = 3'h0;
    wdt_en        = 1'b1;
    xtal_done     = 1'b0;
    pll_lock      = 1'b0;
    tick          = 1'b0;
    fail          = 1'b0;
    reg_addr      = 4'h0;
    reg_wdata     = 16'h0000;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    instr_valid   = 1'b0;
    instr_operand = 1'b0;
    irq           = 1'b0;
    wdt_to        = 1'b0;
    want_src      = 3'h0;
    s_disabled();
    s_redundant();
    s_switch();
    s_fail();
    s_sleep();
    s_idle(1'b0);
    s_idle(1'b1);
    final_report();
  end
endmodule
`default_nettype wire
